// File: design/pfh_device.sv
`timescale 1ns/1ps
// ****************************************
// front end register bank, device end
// ****************************************
// Operation
// - select pin high picks converter registers
// - power down pin stops serial link, pulls ready lines low
// - registers keep contents through shutdown
// - overcurrent limits; enabled sets bit6, interrupt
// - fault flags stay set until cleared
// - overcurrent disabled: limit only, no flag
// - overtemperature disables stage, hysteresis resume
// - overtemperature enabled sets bit5, interrupt
// - overtemperature disabled: stage off, no flag
// - interrupt pin low; host reads flags
// - enables D6 and D5 independent
// - enables reset zero; host writes D7 zero
// - host writes bits 5-7 after power-up
// - transmit ready open drain, high when ready
// - receive ready open drain, high when ready
// - transmit and receive calibration modes selectable
// - frame: direction, address, eight data bits
// - change on falling, sample on rising
// - bit15 direction, bits 14:8 address
module pfh_device #(
    parameter logic [7:0] DIE_IDENTITY_VAL = 8'h5a,  // arbitrary value
    parameter logic [7:0] DIE_REV_VAL = 8'h0c  // arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pfh_link_if.dev link,
    input wire logic overcurrent_i,
    input wire logic temp_trip_i,
    input wire logic temp_resume_i,
    input wire logic tx_path_ready_i,
    input wire logic rx_path_ready_i,
    output logic current_limit_o,
    output logic driver_stage_en_o,
    output logic low_power_o,
    output logic cal_tx_o,
    output logic cal_rx_o,
    output logic [7:0] block_enable_a_o,
    output logic [7:0] gain_select_o,
    output logic [7:0] block_enable_b_o,
    output logic conv_wr_o,
    output logic [6:0] conv_addr_o,
    output logic [7:0] conv_data_o
);
    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic sclk_s, cs_n_s, mosi_s, conv_s, pd_s, oc_s, trip_s, resume_s, txr_s, rxr_s;
    logic sclk_d_r;
    logic rise, fall, active;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= {link.sclk, link.cs_n, link.mosi, link.conv_sel, link.power_down,
                     overcurrent_i, temp_trip_i, temp_resume_i, tx_path_ready_i,
                     rx_path_ready_i};
            s2_r <= s1_r;
        end
    end

    assign {sclk_s, cs_n_s, mosi_s, conv_s, pd_s, oc_s, trip_s, resume_s, txr_s, rxr_s} = s2_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_s;
    end

    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;
    assign active = ~cs_n_s & ~pd_s;

    // ****************************************
    // frame receiver
    // ****************************************
    logic [4:0] cnt_r;
    logic [6:0] sh_r;
    logic [7:0] cmd_r;
    logic [7:0] rd_sh_r;
    logic miso_r;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [6:0] addr;

    localparam int ADDR_LSB = 0;
    assign addr = cmd_r[ADDR_LSB+6:ADDR_LSB];

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !active)
        begin
            cnt_r <= '0;
            sh_r <= '0;
        end
        else if (rise && cnt_r < 5'(pfh_pkg::FRAME_BITS))
        begin
            sh_r <= {sh_r[5:0], mosi_s};
            cnt_r <= cnt_r + 5'd1;
        end
    end

    // command byte: direction then address
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cmd_r <= '0;
        else if (active && rise && cnt_r == 5'(pfh_pkg::CMD_BITS - 1))
            cmd_r <= {sh_r, mosi_s};
    end

    assign wr_stb = active && rise && cnt_r == 5'(pfh_pkg::FRAME_BITS - 1)
                    && cmd_r[7] != pfh_pkg::RW_READ;
    assign wr_data = {sh_r, mosi_s};

    function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] ea,
                                          input logic [7:0] g, input logic [7:0] eb,
                                          input logic [7:0] c, input logic [7:0] ie,
                                          input logic [7:0] f);
        case (a)
            pfh_pkg::REG_EN_A: rd_mux = ea;
            pfh_pkg::REG_GAIN: rd_mux = g;
            pfh_pkg::REG_EN_B: rd_mux = eb;
            pfh_pkg::REG_CAL: rd_mux = c;
            pfh_pkg::REG_IRQ_EN: rd_mux = ie;
            pfh_pkg::REG_FAULT: rd_mux = f;
            pfh_pkg::REG_DIE_IDENTITY: rd_mux = DIE_IDENTITY_VAL;
            pfh_pkg::REG_DIE_REV: rd_mux = DIE_REV_VAL;
            default: rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    // ****************************************
    // register bank
    // ****************************************
    logic [7:0] en_a_r, gain_r, en_b_r, cal_r, irq_en_r;
    logic ioc_flag_r, ot_flag_r;
    logic reg_wr;
    logic [7:0] cal_rd, fault_rd, rd_val;

    assign reg_wr = wr_stb && !conv_s;

    // contents only change on a completed frame, so shutdown keeps them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en_a_r <= pfh_pkg::RST_EN_A;
            gain_r <= pfh_pkg::RST_GAIN;
            en_b_r <= pfh_pkg::RST_EN_B;
            cal_r <= pfh_pkg::RST_CAL;
            irq_en_r <= pfh_pkg::RST_IRQ_EN;
        end
        else if (reg_wr)
        begin
            case (addr)
                pfh_pkg::REG_EN_A: en_a_r <= wr_data;
                pfh_pkg::REG_GAIN: gain_r <= wr_data;
                pfh_pkg::REG_EN_B: en_b_r <= wr_data;
                pfh_pkg::REG_CAL: cal_r <= wr_data;
                pfh_pkg::REG_IRQ_EN: irq_en_r <= wr_data;
                default: ;
            endcase
        end
    end

    // ****************************************
    // fault flags
    // ****************************************
    logic fault_wr;
    assign fault_wr = reg_wr && addr == pfh_pkg::REG_FAULT;

    // set wins over the clearing write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ioc_flag_r <= 1'b0;
            ot_flag_r <= 1'b0;
        end
        else
        begin
            ioc_flag_r <= (oc_s & irq_en_r[pfh_pkg::IOC_EN_BIT])
                        | (ioc_flag_r & ~(fault_wr & wr_data[pfh_pkg::IOC_FLAG_BIT]));
            ot_flag_r <= (trip_s & irq_en_r[pfh_pkg::OT_EN_BIT])
                       | (ot_flag_r & ~(fault_wr & wr_data[pfh_pkg::OT_FLAG_BIT]));
        end
    end

    always_comb
    begin
        fault_rd = 8'h00;
        fault_rd[pfh_pkg::IOC_FLAG_BIT] = ioc_flag_r;
        fault_rd[pfh_pkg::OT_FLAG_BIT] = ot_flag_r;
        cal_rd = cal_r;
        cal_rd[pfh_pkg::CAL_TX_RDY_BIT] = txr_s & en_a_r[pfh_pkg::EN_A_TX_BIT];
        cal_rd[pfh_pkg::CAL_RX_RDY_BIT] = rxr_s & en_a_r[pfh_pkg::EN_A_RX_BIT];
    end

    assign rd_val = conv_s ? 8'h00
                  : rd_mux(addr, en_a_r, gain_r, en_b_r, cal_rd, irq_en_r, fault_rd);

    // ****************************************
    // read data shifter
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_sh_r <= '0;
            miso_r <= 1'b0;
        end
        else if (active && fall && cmd_r[7] == pfh_pkg::RW_READ)
        begin
            if (cnt_r == 5'(pfh_pkg::CMD_BITS))
            begin
                miso_r <= rd_val[7];
                rd_sh_r <= {rd_val[6:0], 1'b0};
            end
            else if (cnt_r > 5'(pfh_pkg::CMD_BITS) && cnt_r < 5'(pfh_pkg::FRAME_BITS))
            begin
                miso_r <= rd_sh_r[7];
                rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
        end
    end

    assign link.miso = miso_r;
    assign link.miso_oe = active && cmd_r[7] == pfh_pkg::RW_READ
                          && cnt_r >= 5'(pfh_pkg::CMD_BITS);

    // ****************************************
    // converter path writes
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_wr_o <= 1'b0;
            conv_addr_o <= '0;
            conv_data_o <= '0;
        end
        else
        begin
            conv_wr_o <= wr_stb && conv_s;
            if (wr_stb && conv_s)
            begin
                conv_addr_o <= addr;
                conv_data_o <= wr_data;
            end
        end
    end

    // ****************************************
    // protection and pins
    // ****************************************
    logic stage_off_r, irq_n_r, tx_rel_r, rx_rel_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stage_off_r <= 1'b0;
        else if (trip_s)
            stage_off_r <= 1'b1;
        else if (resume_s)
            stage_off_r <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_n_r <= 1'b1;
            tx_rel_r <= 1'b0;
            rx_rel_r <= 1'b0;
        end
        else
        begin
            irq_n_r <= ~(ioc_flag_r | ot_flag_r);
            tx_rel_r <= cal_rd[pfh_pkg::CAL_TX_RDY_BIT] & ~pd_s;
            rx_rel_r <= cal_rd[pfh_pkg::CAL_RX_RDY_BIT] & ~pd_s;
        end
    end

    assign link.irq_n = irq_n_r;
    assign link.tx_rdy_o = 1'b0;
    assign link.tx_rdy_oe = ~tx_rel_r;
    assign link.rx_rdy_o = 1'b0;
    assign link.rx_rdy_oe = ~rx_rel_r;

    assign current_limit_o = oc_s;
    assign driver_stage_en_o = ~stage_off_r;
    assign low_power_o = pd_s;
    assign cal_tx_o = cal_r[pfh_pkg::CAL_TX_BIT];
    assign cal_rx_o = cal_r[pfh_pkg::CAL_RX_BIT];
    assign block_enable_a_o = en_a_r;
    assign gain_select_o = gain_r;
    assign block_enable_b_o = en_b_r;
endmodule : pfh_device

// File: design/pfh_host.sv
`timescale 1ns/1ps
// ****************************************
// front end controller, host end
// ****************************************
module pfh_host #(
    parameter int HALF_CYC = pfh_pkg::SCLK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    pfh_link_if.host link
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] s1_r, s2_r;
    logic miso_s, irq_n_s, txr_s, rxr_s;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= 4'h4;
            s2_r <= 4'h4;
        end
        else
        begin
            s1_r <= {link.miso_line, link.irq_n, link.tx_rdy_line, link.rx_rdy_line};
            s2_r <= s1_r;
        end
    end

    assign {miso_s, irq_n_s, txr_s, rxr_s} = s2_r;

    // ****************************************
    // wishbone slave
    // ****************************************
    logic ack_r, pd_r, start;
    logic [16:0] cmd_r;
    logic [7:0] rdata_r;
    pfh_pkg::pfh_host_state_t st_r;
    logic req;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign start = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1] && wb_sel_i[2]
                   && wb_adr_i == pfh_pkg::HOST_CMD_OFS && st_r == pfh_pkg::ST_IDLE;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pd_r <= 1'b0;
        else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == pfh_pkg::HOST_CTRL_OFS)
            pd_r <= wb_dat_i[pfh_pkg::CTRL_PD_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (req)
        begin
            case (wb_adr_i)
                pfh_pkg::HOST_CMD_OFS: wb_dat_o <= {15'h0000, cmd_r};
                pfh_pkg::HOST_STAT_OFS: wb_dat_o <= {28'h0000000, rxr_s, txr_s, ~irq_n_s,
                                                     st_r != pfh_pkg::ST_IDLE};
                pfh_pkg::HOST_RDATA_OFS: wb_dat_o <= {24'h000000, rdata_r};
                pfh_pkg::HOST_CTRL_OFS: wb_dat_o <= {31'h00000000, pd_r};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    assign wb_ack_o = ack_r;

    // ****************************************
    // frame sequencer
    // ****************************************
    logic [15:0] div_r;
    logic [3:0] bit_r;
    logic [15:0] tx_sh_r;
    logic sclk_r, cs_n_r, tick;

    assign tick = div_r == 16'(HALF_CYC - 1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_r == pfh_pkg::ST_IDLE || tick)
            div_r <= '0;
        else
            div_r <= div_r + 16'd1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= pfh_pkg::ST_IDLE;
            cmd_r <= '0;
            tx_sh_r <= '0;
            bit_r <= '0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            rdata_r <= '0;
        end
        else
        begin
            case (st_r)
                pfh_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        cmd_r <= wb_dat_i[16:0];
                        tx_sh_r <= wb_dat_i[15:0];
                        bit_r <= '0;
                        cs_n_r <= 1'b0;
                        st_r <= pfh_pkg::ST_LOW;
                    end
                end
                pfh_pkg::ST_LOW:
                begin
                    if (tick)
                    begin
                        sclk_r <= 1'b1;
                        if (bit_r >= 4'd8)
                            rdata_r <= {rdata_r[6:0], miso_s};
                        st_r <= pfh_pkg::ST_HIGH;
                    end
                end
                pfh_pkg::ST_HIGH:
                begin
                    if (tick)
                    begin
                        sclk_r <= 1'b0;
                        if (bit_r == 4'd15)
                            st_r <= pfh_pkg::ST_DONE;
                        else
                        begin
                            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                            bit_r <= bit_r + 4'd1;
                            st_r <= pfh_pkg::ST_LOW;
                        end
                    end
                end
                pfh_pkg::ST_DONE:
                begin
                    if (tick)
                    begin
                        cs_n_r <= 1'b1;
                        st_r <= pfh_pkg::ST_IDLE;
                    end
                end
                default: st_r <= pfh_pkg::ST_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.mosi = tx_sh_r[15];
    assign link.conv_sel = cmd_r[pfh_pkg::CMD_CONV_BIT];
    assign link.power_down = pd_r;
endmodule : pfh_host

// File: design/pfh_link_if.sv
`timescale 1ns/1ps
// ****************************************
// serial link and status pins
// ****************************************
interface pfh_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic conv_sel;
    logic power_down;
    logic irq_n;
    logic tx_rdy_o;
    logic tx_rdy_oe;
    logic rx_rdy_o;
    logic rx_rdy_oe;
    logic miso_line;
    logic tx_rdy_line;
    logic rx_rdy_line;

    // resolved wire levels, open drain lines pulled up
    assign miso_line = miso_oe ? miso : 1'b0;
    assign tx_rdy_line = tx_rdy_oe ? tx_rdy_o : 1'b1;
    assign rx_rdy_line = rx_rdy_oe ? rx_rdy_o : 1'b1;

    modport dev (
        input sclk, cs_n, mosi, conv_sel, power_down,
        output miso, miso_oe, irq_n, tx_rdy_o, tx_rdy_oe, rx_rdy_o, rx_rdy_oe
    );
    modport host (
        output sclk, cs_n, mosi, conv_sel, power_down,
        input miso_line, irq_n, tx_rdy_line, rx_rdy_line
    );
endinterface : pfh_link_if

// File: design/pfh_pkg.sv
// ****************************************
// shared constants
// ****************************************
package pfh_pkg;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS = 8;
    localparam int RW_BIT = 15;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic RW_READ = 1'b1;
    // register offsets
    localparam logic [6:0] REG_EN_A = 7'h01;
    localparam logic [6:0] REG_GAIN = 7'h02;
    localparam logic [6:0] REG_EN_B = 7'h03;
    localparam logic [6:0] REG_CAL = 7'h04;
    localparam logic [6:0] REG_IRQ_EN = 7'h05;
    localparam logic [6:0] REG_FAULT = 7'h09;
    localparam logic [6:0] REG_DIE_IDENTITY = 7'h0a;
    localparam logic [6:0] REG_DIE_REV = 7'h0b;
    // reset values
    localparam logic [7:0] RST_EN_A = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h32;
    localparam logic [7:0] RST_EN_B = 8'h00;
    localparam logic [7:0] RST_CAL = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h01;
    // field positions
    localparam int EN_A_TX_BIT = 1;
    localparam int EN_A_RX_BIT = 2;
    localparam int CAL_TX_BIT = 0;
    localparam int CAL_RX_BIT = 1;
    localparam int CAL_TX_RDY_BIT = 6;
    localparam int CAL_RX_RDY_BIT = 7;
    localparam int IOC_EN_BIT = 6;
    localparam int OT_EN_BIT = 5;
    localparam int IOC_FLAG_BIT = 6;
    localparam int OT_FLAG_BIT = 5;
    // host wishbone map
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
    localparam logic [7:0] HOST_CTRL_OFS = 8'h0c;
    localparam int CMD_CONV_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_IRQ_BIT = 1;
    localparam int STAT_TXRDY_BIT = 2;
    localparam int STAT_RXRDY_BIT = 3;
    localparam int CTRL_PD_BIT = 0;
    // timing
    localparam int CLK_MHZ = 10;
    localparam int SCLK_HALF_NS = 800;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;
    // host sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11,
        ST_DONE = 2'b10
    } pfh_host_state_t;
endpackage : pfh_pkg

// File: verification/pfh_link_asserts.sv
`timescale 1ns/1ps
// ****************
// link checker
// ****************
module pfh_link_asserts #(
    parameter int HALF_CYC = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic power_down,
    input wire logic tx_rdy_o,
    input wire logic tx_rdy_oe,
    input wire logic rx_rdy_o,
    input wire logic rx_rdy_oe
);
    int hi_cnt;
    logic [4:0] rise_cnt;
    logic sclk_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // length of the current high phase
    always_ff @(posedge clk_i)
    begin
        hi_cnt <= (rst_i || !sclk) ? 0 : hi_cnt + 1;
    end
    // rising edges seen in the current frame
    always_ff @(posedge clk_i)
    begin
        sclk_q <= sclk;
        rise_cnt <= (rst_i || cs_n) ? 5'h00 : rise_cnt + 5'(sclk && !sclk_q);
    end
    a_idle_sclk_low: assert property (cs_n |-> !sclk)
        else $error("serial clock active while deselected");
    a_mosi_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(mosi) |-> $fell(sclk))
        else $error("host data changed away from a falling edge");
    a_miso_hold_high: assert property (sclk && $past(sclk) && miso_oe && $past(miso_oe)
        |-> $stable(miso))
        else $error("device data changed while serial clock high");
    a_sclk_half: assert property ($fell(sclk) |-> hi_cnt == HALF_CYC)
        else $error("serial clock high phase has wrong length");
    a_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
        else $error("frame does not carry sixteen bits");
    a_miso_off_idle: assert property (cs_n[*5] |-> !miso_oe)
        else $error("device drives data while deselected");
    a_pd_miso_off: assert property (power_down[*5] |-> !miso_oe && tx_rdy_oe && rx_rdy_oe)
        else $error("device active during shutdown");
    a_open_drain: assert property (!(tx_rdy_oe && tx_rdy_o) && !(rx_rdy_oe && rx_rdy_o))
        else $error("ready line driven high");
endmodule : pfh_link_asserts

// File: verification/plc_frontend_host_control_test.sv
`timescale 1ns/1ps
module plc_frontend_host_control_test;
    // ****************
    // clock, wiring
    // ****************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_rdat;
    logic oc = 1'b0, trip = 1'b0, resume = 1'b1, txp = 1'b0, rxp = 1'b0, pd = 1'b0;
    logic climit, stage_en, low_pwr, cal_tx, cal_rx, conv_wr;
    logic [7:0] en_a, conv_data, q, conv_cnt = 8'h00;
    logic [6:0] conv_addr;
    logic [14:0] conv_cap;
    logic [15:0] cap;
    logic [31:0] rsp;
    logic sclk_q = 1'b0;
    logic [7:0] m [0:15] = '{default: 8'h00};
    int bad_count = 0, num_checks = 0;
    always #50 clk_i = ~clk_i;
    pfh_link_if link ();
    pfh_device i_pfh_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .overcurrent_i(oc),
        .temp_trip_i(trip), .temp_resume_i(resume), .tx_path_ready_i(txp),
        .rx_path_ready_i(rxp), .current_limit_o(climit), .driver_stage_en_o(stage_en),
        .low_power_o(low_pwr), .cal_tx_o(cal_tx), .cal_rx_o(cal_rx), .block_enable_a_o(en_a),
        .gain_select_o(), .block_enable_b_o(), .conv_wr_o(conv_wr), .conv_addr_o(conv_addr),
        .conv_data_o(conv_data));
    pfh_host #(.HALF_CYC(pfh_pkg::SCLK_HALF_CYC)) i_pfh_host (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));
    pfh_link_asserts #(.HALF_CYC(pfh_pkg::SCLK_HALF_CYC)) i_pfh_link_asserts (.clk_i(clk_i),
        .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
        .miso_oe(link.miso_oe), .power_down(link.power_down), .tx_rdy_o(link.tx_rdy_o),
        .tx_rdy_oe(link.tx_rdy_oe), .rx_rdy_o(link.rx_rdy_o), .rx_rdy_oe(link.rx_rdy_oe));
    // wire monitor: frame bits and converter writes
    always @(posedge clk_i)
    begin
        sclk_q <= link.sclk;
        if (link.sclk && !sclk_q && !link.cs_n)
            cap <= {cap[14:0], link.mosi};
        if (conv_wr === 1'b1)
        begin
            conv_cnt <= conv_cnt + 8'h01;
            conv_cap <= {conv_addr, conv_data};
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : waitc
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            conclude();
        end
        r = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    task automatic spi(input logic conv, input logic rw, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] rd);
        logic [31:0] r;
        int n;
        wb(1'b1, pfh_pkg::HOST_CMD_OFS, {15'h0, conv, rw, a, d}, r);
        n = 0;
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 400)
        begin
            wb(1'b0, pfh_pkg::HOST_STAT_OFS, 32'h0, r);
            n++;
        end
        if (n >= 400)
        begin
            bad_count++;
            conclude();
        end
        chk("frame", {cap[15:8], rw ? 8'h00 : cap[7:0]}, {rw, a, rw ? 8'h00 : d});
        wb(1'b0, pfh_pkg::HOST_RDATA_OFS, 32'h0, r);
        rd = r[7:0];
    endtask : spi
    function automatic logic [7:0] exp_rd(input logic [6:0] a);
        case (a)
            7'h01, 7'h02, 7'h03, 7'h05, 7'h09: return m[a[3:0]];
            7'h04: return {m[1][2] & rxp & !pd, m[1][1] & txp & !pd, 4'h0, m[4][1:0]};
            7'h0a: return 8'h5a;
            7'h0b: return 8'h0c;
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    task automatic rd_chk(input logic [6:0] a);
        spi(1'b0, 1'b1, a, 8'h00, q);
        chk("register read", q, exp_rd(a));
    endtask : rd_chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi(1'b0, 1'b0, a, d, q);
        if (a >= 7'h01 && a <= 7'h05)
            m[a[3:0]] = d;
        if (a == 7'h09)
            m[9] = m[9] & ~d;
    endtask : wr
    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        conclude();
    end
    initial
    begin
        void'($urandom(42));
        m[2] = 8'h32;
        m[5] = 8'h01;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) rd_chk(7'(i));
        wr(7'h0a, 8'hff);
        rd_chk(7'h0a);
        for (int i = 0; i < 6; i++)
        begin
            wr(7'(1 + i % 3), 8'($urandom));
            rd_chk(7'(1 + i % 3));
        end
        chk("enable a", en_a, m[1]);
        for (int i = 0; i < 4; i++)
        begin
            wr(7'h04, 8'(i));
            chk("cal mode", {cal_rx, cal_tx}, i);
        end
        spi(1'b1, 1'b0, 7'h02, 8'ha5, q);
        chk("converter write", {conv_cnt, conv_cap}, {8'h01, 7'h02, 8'ha5});
        rd_chk(7'h02);
        @(posedge clk_i) txp <= 1'b1;
        rxp <= 1'b1;
        wr(7'h01, 8'h06);
        waitc(6);
        chk("ready lines", {link.rx_rdy_line, link.tx_rdy_line}, 2'b11);
        wb(1'b0, pfh_pkg::HOST_STAT_OFS, 32'h0, rsp);
        chk("host status", rsp[3:0], 4'b1100);
        rd_chk(7'h04);
        @(posedge clk_i) txp <= 1'b0;
        waitc(6);
        chk("ready lines", {link.rx_rdy_line, link.tx_rdy_line}, 2'b10);
        for (int i = 0; i < 4; i++)
        begin
            wr(7'h05, i[1] ? 8'h60 : 8'h00);
            @(posedge clk_i) {trip, resume, oc} <= i[0] ? 3'b100 : 3'b011;
            waitc(8);
            chk("protection", {climit, stage_en}, i[0] ? 2'b00 : 2'b11);
            @(posedge clk_i) {trip, oc} <= 2'b00;
            waitc(8);
            chk("stage hold", stage_en, !i[0]);
            @(posedge clk_i) resume <= 1'b1;
            waitc(8);
            chk("stage resume", stage_en, 1'b1);
            if (i[1])
                m[9][i[0] ? 5 : 6] = 1'b1;
            chk("interrupt pin", link.irq_n, !i[1]);
            rd_chk(7'h09);
            wr(7'h09, 8'h60);
            rd_chk(7'h09);
            chk("interrupt pin", link.irq_n, 1'b1);
        end
        wb(1'b1, pfh_pkg::HOST_CTRL_OFS, 32'h1, rsp);
        pd = 1'b1;
        waitc(8);
        chk("shutdown", {low_pwr, link.rx_rdy_line}, 2'b10);
        spi(1'b0, 1'b0, 7'h02, ~m[2], q);
        wb(1'b1, pfh_pkg::HOST_CTRL_OFS, 32'h0, rsp);
        pd = 1'b0;
        waitc(8);
        rd_chk(7'h02);
        rd_chk(7'h04);
        conclude();
    end
endmodule : plc_frontend_host_control_test
